// ===== rtl/mior_device.sv
// Our own choices: the placing of the registers and strobed register access.
module mior_device (
  input  wire logic        core_clk,
  input  wire logic        nrst,
  mior_link_if.device      link,
  input  wire logic        quadLaneEnable,
  input  wire logic        fourLaneCommandMode,
  input  wire logic        resetCmd,
  input  wire logic        setWrap,
  input  wire logic [2:0]  wrapBits,
  input  wire logic        setReadParams,
  input  wire logic [1:0]  dummySelIn,
  input  wire logic [7:0]  memData,
  output logic      [23:0] memAddr,
  output logic             memRead,
  output logic             continuationActive
);

  typedef enum logic [2:0] {
    D_IDLE   = 3'b000,
    D_CMD    = 3'b001,
    D_ADDR   = 3'b010,
    D_MODE   = 3'b011,
    D_DUMMY  = 3'b100,
    D_DATA   = 3'b101,
    D_IGNORE = 3'b110
  } mior_dst_t;

  typedef struct packed {
    logic        csS1;
    logic        csS2;
    logic        clkS1;
    logic        clkS2;
    logic        clkS3;
    logic [3:0]  laneS1;
    logic [3:0]  laneS2;
    mior_dst_t   st;
    logic [7:0]  cmd;
    logic [2:0]  width;
    logic [5:0]  cnt;
    logic [23:0] addr;
    logic [7:0]  cont;
    logic        contMode;
    logic [7:0]  contCmd;
    logic        wrapDis;
    logic [1:0]  wrapSize;
    logic [1:0]  dummySel;
    logic [7:0]  sh;
    logic [2:0]  chunk;
    logic        load;
    logic [23:0] memAddr;
    logic [3:0]  dout;
    logic [3:0]  doeN;
  } mior_dev_t;

  mior_dev_t r_reg;
  mior_dev_t r_next;

  function automatic logic cmdAccepted(input logic [7:0] c,
                                       input logic four_lane_command_mode,
                                       input logic qe);
    cmdAccepted = (c == mior_pkg::CMD_DUAL_IO && !four_lane_command_mode) ||
                  (c == mior_pkg::CMD_QUAD_IO && qe) ||
                  (c == mior_pkg::CMD_WORD_IO && qe && !four_lane_command_mode);
  endfunction

  // Dummy clocks left after the continuation byte
  function automatic logic [5:0] dummiesFor(input logic [7:0] c,
                                            input logic four_lane_command_mode,
                                            input logic [1:0] sel);
    if (four_lane_command_mode) begin
      dummiesFor = {3'b000, sel, 1'b0};
    end else if (c == mior_pkg::CMD_QUAD_IO) begin
      dummiesFor = mior_pkg::QUAD_DUMMIES;
    end else if (c == mior_pkg::CMD_WORD_IO) begin
      dummiesFor = mior_pkg::WORD_DUMMIES;
    end else begin
      dummiesFor = 6'h00;
    end
  endfunction

  function automatic logic [3:0] shiftIn4(input logic [3:0] lanes,
                                          input logic [2:0] w);
    shiftIn4 = (w == 3'h2) ? {2'b00, lanes[1:0]} : lanes;
  endfunction

  logic        rise;
  logic        fall;
  logic        four_lane_command_mode;
  logic        wrapOn;
  logic [23:0] wrapMask;
  logic [23:0] nextAddr;
  logic [7:0]  cmdShift;
  logic [7:0]  contShift;
  logic [5:0]  dum;

  always_comb begin
    rise = r_reg.clkS2 & ~r_reg.clkS3;
    fall = ~r_reg.clkS2 & r_reg.clkS3;
    four_lane_command_mode  = fourLaneCommandMode;
    // Wrap only for single-command-lane quad and word reads
    wrapOn = !four_lane_command_mode && !r_reg.wrapDis &&
             (r_reg.cmd == mior_pkg::CMD_QUAD_IO ||
              r_reg.cmd == mior_pkg::CMD_WORD_IO);
    wrapMask = 24'((8 << r_reg.wrapSize) - 1);
    nextAddr = wrapOn ? ((r_reg.addr & ~wrapMask) |
                         ((r_reg.addr + 24'h1) & wrapMask))
                      : r_reg.addr + 24'h1;
    cmdShift = four_lane_command_mode ? {r_reg.cmd[3:0], r_reg.laneS2}
                   : {r_reg.cmd[6:0], r_reg.laneS2[0]};
    contShift = (r_reg.width == 3'h2) ?
                {r_reg.cont[5:0], r_reg.laneS2[1:0]} :
                {r_reg.cont[3:0], r_reg.laneS2};
    dum = dummiesFor(r_reg.cmd, four_lane_command_mode, r_reg.dummySel);

    r_next = r_reg;
    r_next.csS1   = link.csN;
    r_next.csS2   = r_reg.csS1;
    r_next.clkS1  = link.sclk;
    r_next.clkS2  = r_reg.clkS1;
    r_next.clkS3  = r_reg.clkS2;
    r_next.laneS1 = link.lane;
    r_next.laneS2 = r_reg.laneS1;
    r_next.load   = 1'b0;
    if (r_reg.load) begin
      r_next.sh = memData;
    end

    if (setWrap) begin
      r_next.wrapDis  = wrapBits[0];
      r_next.wrapSize = wrapBits[2:1];
    end
    if (setReadParams) begin
      r_next.dummySel = dummySelIn;
    end

    if (r_reg.csS2) begin
      r_next.st   = D_IDLE;
      r_next.doeN = 4'hF;
    end else begin
      unique case (r_reg.st)
        D_IDLE: begin
          if (r_reg.contMode) begin
            r_next.st    = D_ADDR;
            r_next.cmd   = r_reg.contCmd;
            r_next.width = mior_pkg::laneWidth(r_reg.contCmd);
            r_next.cnt   = mior_pkg::clocksFor(mior_pkg::ADDR_BITS,
                             mior_pkg::laneWidth(r_reg.contCmd));
          end else begin
            r_next.st  = D_CMD;
            r_next.cnt = four_lane_command_mode ? mior_pkg::QPI_CMD_CLKS
                             : mior_pkg::SPI_CMD_CLKS;
          end
        end
        D_CMD: begin
          if (rise) begin
            r_next.cmd = cmdShift;
            r_next.cnt = r_reg.cnt - 6'h1;
            if (r_reg.cnt == 6'h1) begin
              r_next.width = mior_pkg::laneWidth(cmdShift);
              r_next.cnt   = mior_pkg::clocksFor(mior_pkg::ADDR_BITS,
                               mior_pkg::laneWidth(cmdShift));
              r_next.st = cmdAccepted(cmdShift, four_lane_command_mode, quadLaneEnable) ?
                          D_ADDR : D_IGNORE;
            end
          end
        end
        D_ADDR: begin
          if (rise) begin
            r_next.addr = (r_reg.width == 3'h2) ?
                          {r_reg.addr[21:0], r_reg.laneS2[1:0]} :
                          {r_reg.addr[19:0], r_reg.laneS2};
            r_next.cnt = r_reg.cnt - 6'h1;
            if (r_reg.cnt == 6'h1) begin
              r_next.st  = D_MODE;
              r_next.cnt = mior_pkg::clocksFor(mior_pkg::CONT_BITS,
                                               r_reg.width);
            end
          end
        end
        D_MODE: begin
          if (rise) begin
            r_next.cont = contShift;
            r_next.cnt  = r_reg.cnt - 6'h1;
            if (r_reg.cnt == 6'h1) begin
              // Low nibble never looked at
              r_next.contMode = (contShift[5:4] == mior_pkg::CONT_CODE);
              r_next.contCmd  = r_reg.cmd;
              r_next.cnt      = dum;
              if (dum == 6'h00) begin
                r_next.st      = D_DATA;
                r_next.memAddr = r_reg.addr;
                r_next.load    = 1'b1;
                r_next.chunk   = (r_reg.width == 3'h2) ? 3'h4 : 3'h2;
              end else begin
                r_next.st = D_DUMMY;
              end
            end
          end
        end
        D_DUMMY: begin
          if (rise) begin
            r_next.cnt = r_reg.cnt - 6'h1;
            if (r_reg.cnt == 6'h1) begin
              r_next.st      = D_DATA;
              r_next.memAddr = r_reg.addr;
              r_next.load    = 1'b1;
              r_next.chunk   = (r_reg.width == 3'h2) ? 3'h4 : 3'h2;
            end
          end
        end
        D_DATA: begin
          if (fall) begin
            // Most significant bits leave first, on the highest lane
            r_next.doeN  = (r_reg.width == 3'h2) ? 4'hC : 4'h0;
            r_next.dout  = (r_reg.width == 3'h2) ?
                           {2'b00, r_reg.sh[7:6]} : r_reg.sh[7:4];
            r_next.sh    = (r_reg.width == 3'h2) ?
                           {r_reg.sh[5:0], 2'b00} :
                           {r_reg.sh[3:0], 4'h0};
            r_next.chunk = r_reg.chunk - 3'h1;
            if (r_reg.chunk == 3'h1) begin
              r_next.addr    = nextAddr;
              r_next.memAddr = nextAddr;
              r_next.load    = 1'b1;
              r_next.chunk   = (r_reg.width == 3'h2) ? 3'h4 : 3'h2;
            end
          end
        end
        D_IGNORE: begin
          r_next.doeN = 4'hF;
        end
        default: begin
          r_next.st = D_IGNORE;
        end
      endcase
    end

    if (resetCmd) begin
      r_next.contMode = 1'b0;
      r_next.dummySel = mior_pkg::DUMMY_SEL_RST;
      r_next.wrapDis  = mior_pkg::WRAP_DIS_RST;
      r_next.wrapSize = mior_pkg::WRAP_SIZE_RST;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      r_reg          <= '0;
      r_reg.csS1     <= 1'b1;
      r_reg.csS2     <= 1'b1;
      r_reg.st       <= D_IDLE;
      r_reg.doeN     <= 4'hF;
      r_reg.wrapDis  <= mior_pkg::WRAP_DIS_RST;
      r_reg.wrapSize <= mior_pkg::WRAP_SIZE_RST;
      r_reg.dummySel <= mior_pkg::DUMMY_SEL_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  assign link.devOut        = r_reg.dout;
  assign link.devOeN        = r_reg.doeN;
  assign memAddr            = r_reg.memAddr;
  assign memRead            = r_reg.load;
  assign continuationActive = r_reg.contMode;

endmodule

// ===== rtl/mior_host.sv
module mior_host (
  input  wire logic        core_clk,
  input  wire logic        nrst,
  mior_link_if.host        link,
  input  wire logic        reqValid,
  input  wire logic [7:0]  reqCmd,
  input  wire logic [23:0] reqAddr,
  input  wire logic [7:0]  reqCont,
  input  wire logic [5:0]  reqDummy,
  input  wire logic [7:0]  reqBytes,
  input  wire logic        reqSkipCmd,
  input  wire logic        reqQpi,
  input  wire logic        reqExit,
  output logic             busy,
  output logic      [7:0]  rdData,
  output logic             rdValid
);

  typedef enum logic [2:0] {
    H_IDLE  = 3'b000,
    H_CMD   = 3'b001,
    H_ADDR  = 3'b010,
    H_DUMMY = 3'b011,
    H_DATA  = 3'b100,
    H_EXIT  = 3'b101,
    H_DONE  = 3'b110,
    H_GAP   = 3'b111
  } mior_hst_t;

  typedef struct packed {
    mior_hst_t   st;
    logic [2:0]  div;
    logic        sclk;
    logic        csN;
    logic [5:0]  cnt;
    logic [2:0]  w;
    logic [2:0]  dw;
    logic [39:0] outSh;
    logic [3:0]  laneS1;
    logic [3:0]  laneS2;
    logic [7:0]  inSh;
    logic [2:0]  chunk;
    logic [7:0]  bytesLeft;
    logic [5:0]  dummy;
    logic [3:0]  hOut;
    logic [3:0]  hOeN;
    logic [7:0]  rdData;
    logic        rdValid;
    logic        busy;
  } mior_host_t;

  mior_host_t r_reg;
  mior_host_t r_next;

  function automatic logic [3:0] laneBits(input logic [39:0] sh,
                                          input logic [2:0] w);
    unique case (w)
      3'h1:    laneBits = {3'b000, sh[39]};
      3'h2:    laneBits = {2'b00, sh[39:38]};
      default: laneBits = sh[39:36];
    endcase
  endfunction

  function automatic logic [3:0] laneOeN(input logic [2:0] w);
    unique case (w)
      3'h1:    laneOeN = 4'hE;
      3'h2:    laneOeN = 4'hC;
      default: laneOeN = 4'h0;
    endcase
  endfunction

  logic        tick;
  logic        fallNow;
  logic [39:0] shifted;
  logic [2:0]  reqW;
  logic [39:0] loadSh;

  always_comb begin
    tick    = (r_reg.div == mior_pkg::SCLK_HALF_CYC - 3'h1);
    fallNow = tick && r_reg.sclk;
    unique case (r_reg.w)
      3'h1:    shifted = {r_reg.outSh[38:0], 1'b0};
      3'h2:    shifted = {r_reg.outSh[37:0], 2'b00};
      default: shifted = {r_reg.outSh[35:0], 4'h0};
    endcase
    reqW   = mior_pkg::laneWidth(reqCmd);
    loadSh = reqSkipCmd ? {reqAddr, reqCont, 8'h00}
                        : {reqCmd, reqAddr, reqCont};

    r_next         = r_reg;
    r_next.laneS1  = link.lane;
    r_next.laneS2  = r_reg.laneS1;
    r_next.rdValid = 1'b0;
    r_next.div     = tick ? 3'h0 : r_reg.div + 3'h1;
    if (tick && r_reg.st inside {H_CMD, H_ADDR, H_DUMMY, H_DATA, H_EXIT}) begin
      r_next.sclk = ~r_reg.sclk;
    end

    unique case (r_reg.st)
      H_IDLE: begin
        if (reqValid) begin
          r_next.busy      = 1'b1;
          r_next.csN       = 1'b0;
          r_next.sclk      = 1'b0;
          r_next.div       = 3'h0;
          r_next.dw        = reqW;
          r_next.dummy     = reqDummy;
          r_next.bytesLeft = reqBytes;
          r_next.outSh     = loadSh;
          if (reqExit) begin
            r_next.st   = H_EXIT;
            r_next.cnt  = (reqCmd == mior_pkg::CMD_DUAL_IO) ?
                          mior_pkg::EXIT_CLKS_DUAL :
                          mior_pkg::EXIT_CLKS_QUAD;
            r_next.hOut = 4'h1;
            r_next.hOeN = 4'hE;
          end else if (reqSkipCmd) begin
            r_next.st   = H_ADDR;
            r_next.w    = reqW;
            r_next.cnt  = mior_pkg::clocksFor(mior_pkg::ADDR_BITS +
                                              mior_pkg::CONT_BITS, reqW);
            r_next.hOut = laneBits(loadSh, reqW);
            r_next.hOeN = laneOeN(reqW);
          end else begin
            r_next.st   = H_CMD;
            r_next.w    = reqQpi ? 3'h4 : 3'h1;
            r_next.cnt  = reqQpi ? mior_pkg::QPI_CMD_CLKS
                                 : mior_pkg::SPI_CMD_CLKS;
            r_next.hOut = laneBits(loadSh, reqQpi ? 3'h4 : 3'h1);
            r_next.hOeN = laneOeN(reqQpi ? 3'h4 : 3'h1);
          end
        end
      end
      H_CMD: begin
        if (fallNow) begin
          r_next.outSh = shifted;
          r_next.cnt   = r_reg.cnt - 6'h1;
          r_next.hOut  = laneBits(shifted, r_reg.w);
          if (r_reg.cnt == 6'h1) begin
            r_next.st   = H_ADDR;
            r_next.w    = r_reg.dw;
            r_next.cnt  = mior_pkg::clocksFor(mior_pkg::ADDR_BITS +
                                              mior_pkg::CONT_BITS, r_reg.dw);
            r_next.hOut = laneBits(shifted, r_reg.dw);
            r_next.hOeN = laneOeN(r_reg.dw);
          end
        end
      end
      H_ADDR: begin
        if (fallNow) begin
          r_next.outSh = shifted;
          r_next.cnt   = r_reg.cnt - 6'h1;
          r_next.hOut  = laneBits(shifted, r_reg.w);
          if (r_reg.cnt == 6'h1) begin
            // Release at the end of the continuation byte
            r_next.hOeN  = 4'hF;
            r_next.cnt   = r_reg.dummy;
            r_next.chunk = (r_reg.dw == 3'h2) ? 3'h4 : 3'h2;
            r_next.st    = (r_reg.dummy == 6'h00) ? H_DATA : H_DUMMY;
          end
        end
      end
      H_DUMMY: begin
        if (fallNow) begin
          r_next.cnt = r_reg.cnt - 6'h1;
          if (r_reg.cnt == 6'h1) begin
            r_next.st = H_DATA;
          end
        end
      end
      H_DATA: begin
        // Sample just before each fall: data stood since the last one
        if (fallNow) begin
          r_next.inSh  = (r_reg.dw == 3'h2) ?
                         {r_reg.inSh[5:0], r_reg.laneS2[1:0]} :
                         {r_reg.inSh[3:0], r_reg.laneS2};
          r_next.chunk = r_reg.chunk - 3'h1;
          if (r_reg.chunk == 3'h1) begin
            r_next.chunk     = (r_reg.dw == 3'h2) ? 3'h4 : 3'h2;
            r_next.rdData    = r_next.inSh;
            r_next.rdValid   = 1'b1;
            r_next.bytesLeft = r_reg.bytesLeft - 8'h1;
            if (r_reg.bytesLeft <= 8'h1) begin
              r_next.st = H_DONE;
            end
          end
        end
      end
      H_EXIT: begin
        if (fallNow) begin
          r_next.cnt = r_reg.cnt - 6'h1;
          if (r_reg.cnt == 6'h1) begin
            // Device may start driving after the last exit clock
            r_next.hOeN = 4'hF;
            r_next.st   = H_DONE;
          end
        end
      end
      H_DONE: begin
        if (tick) begin
          r_next.csN  = 1'b1;
          r_next.hOeN = 4'hF;
          r_next.st   = H_GAP;
        end
      end
      H_GAP: begin
        if (tick) begin
          r_next.busy = 1'b0;
          r_next.st   = H_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      r_reg      <= '0;
      r_reg.st   <= H_IDLE;
      r_reg.csN  <= 1'b1;
      r_reg.hOeN <= 4'hF;
    end else begin
      r_reg <= r_next;
    end
  end

  assign link.csN     = r_reg.csN;
  assign link.sclk    = r_reg.sclk;
  assign link.hostOut = r_reg.hOut;
  assign link.hostOeN = r_reg.hOeN;
  assign busy         = r_reg.busy;
  assign rdData       = r_reg.rdData;
  assign rdValid      = r_reg.rdValid;

endmodule

// ===== rtl/mior_link_if.sv
interface mior_link_if;
  logic       csN;
  logic       sclk;
  logic [3:0] hostOut;
  logic [3:0] hostOeN;
  logic [3:0] devOut;
  logic [3:0] devOeN;
  logic [3:0] lane;

  // Undriven lanes float high as through a pull-up
  assign lane = (~hostOeN & hostOut) | (~devOeN & devOut) |
                (hostOeN & devOeN);

  modport device (
    input  csN,
    input  sclk,
    input  lane,
    output devOut,
    output devOeN
  );

  modport host (
    output csN,
    output sclk,
    output hostOut,
    output hostOeN,
    input  lane
  );
endinterface

// ===== rtl/mior_pkg.sv
// Overview of operation
// - Dual read: address, data two bits per clock
// - Continuation byte follows address; low nibble ignored
// - Code 10 makes next read skip command
// - Any other code restores full command byte
// - Host exits dual continuation: sixteen ones
// - Host exits quad continuation: eight ones
// - Host releases lanes before first data edge
// - Quad read: four lanes, four dummy clocks
// - Quad read needs quad lane enable
// - Wrap within aligned section until deselect
// - Wrap disable and size pick section
// - Four-lane mode dummies 2, 4, 6, 8; the code gives 0, 2, 4, 6
// - Four-lane dummy count resets to two; the code resets it to zero
// - Four-lane continuation clocks count as dummies; the code adds the dummies after them
// - Continuation also works in four-lane mode
// - Four-lane quad read never wraps
// - Word read: even address, two dummies
// - Word read needs enable; continuation skips command
// - Wrap off after reset; sizes 8..64 bytes
package mior_pkg;

  localparam logic [7:0] CMD_DUAL_IO   = 8'hBB;
  localparam logic [7:0] CMD_QUAD_IO   = 8'hEB;
  localparam logic [7:0] CMD_WORD_IO   = 8'hE7;
  localparam logic [1:0] CONT_CODE     = 2'h2;
  localparam logic [5:0] ADDR_BITS     = 6'h18;
  localparam logic [5:0] CONT_BITS     = 6'h08;
  localparam logic [5:0] SPI_CMD_CLKS  = 6'h08;
  localparam logic [5:0] QPI_CMD_CLKS  = 6'h02;
  localparam logic [5:0] QUAD_DUMMIES  = 6'h04;
  localparam logic [5:0] WORD_DUMMIES  = 6'h02;
  localparam logic [5:0] EXIT_CLKS_DUAL = 6'h10;
  localparam logic [5:0] EXIT_CLKS_QUAD = 6'h08;
  localparam logic       WRAP_DIS_RST  = 1'b1;
  localparam logic [1:0] WRAP_SIZE_RST = 2'h0;
  localparam logic [1:0] DUMMY_SEL_RST = 2'h0;
  localparam int         CLK_PERIOD_NS  = 8;
  localparam int         SCLK_PERIOD_NS = 80;
  localparam logic [2:0] SCLK_HALF_CYC  =
    3'(SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS));

  // Lanes carried per clock after the command phase
  function automatic logic [2:0] laneWidth(input logic [7:0] cmd);
    laneWidth = (cmd == CMD_DUAL_IO) ? 3'h2 : 3'h4;
  endfunction

  // Clocks needed to move a number of bits at a lane width
  function automatic logic [5:0] clocksFor(input logic [5:0] bits,
                                           input logic [2:0] w);
    clocksFor = (w == 3'h2) ? {1'b0, bits[5:1]} : {2'b00, bits[5:2]};
  endfunction

endpackage

// ===== verification/mior_link_monitor.sv
module mior_link_monitor (
  input wire logic       core_clk,
  input wire logic       nrst,
  input wire logic       csN,
  input wire logic       sclk,
  input wire logic [3:0] hostOut,
  input wire logic [3:0] hostOeN,
  input wire logic [3:0] devOut,
  input wire logic [3:0] devOeN
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  // Half period is five core cycles at an 80 ns link clock
  sequence s_high_phase;
    sclk [*5] ##1 !sclk;
  endsequence
  sequence s_low_phase;
    !sclk [*5];
  endsequence

  property p_no_contention;
    (hostOeN | devOeN) == 4'hF;
  endproperty
  property p_idle_low;
    csN |-> !sclk;
  endproperty
  property p_high_phase;
    $rose(sclk) |-> s_high_phase;
  endproperty
  property p_low_phase;
    $fell(sclk) |-> s_low_phase;
  endproperty
  property p_select_setup;
    $fell(csN) |-> !sclk [*4];
  endproperty
  property p_release;
    $rose(csN) |-> ##[0:3] (devOeN == 4'hF);
  endproperty
  // Device output moves only on falls, never while the clock is high
  property p_dev_stable;
    sclk && $past(sclk) |-> $stable(devOut);
  endproperty
  property p_host_stable;
    sclk |-> $stable(hostOut) && $stable(hostOeN);
  endproperty

  a_no_contention: assert property (p_no_contention)
    else $error("host and device drive a lane together");
  a_idle_low: assert property (p_idle_low)
    else $error("link clock high while deselected");
  a_high_phase: assert property (p_high_phase)
    else $error("link clock high phase not five cycles");
  a_low_phase: assert property (p_low_phase)
    else $error("link clock low phase too short");
  a_select_setup: assert property (p_select_setup)
    else $error("link clock rose too soon after select");
  a_release: assert property (p_release)
    else $error("device kept lanes after deselect");
  a_dev_stable: assert property (p_dev_stable)
    else $error("device output changed while clock high");
  a_host_stable: assert property (p_host_stable)
    else $error("host lanes changed while clock high");
endmodule

// ===== verification/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic        core_clk, nrst, quadLaneEnable, fourLaneCommandMode;
  logic        resetCmd, setWrap, setReadParams, memRead, wrapOn;
  logic        continuationActive, reqValid, reqSkipCmd, reqQpi;
  logic        reqExit, busy, rdValid, sclkD;
  logic [2:0]  wrapBits;
  logic [1:0]  dummySelIn;
  logic [7:0]  memData, reqCmd, reqCont, reqBytes, rdData;
  logic [23:0] memAddr, reqAddr;
  logic [5:0]  reqDummy;
  int          num_errors, total_checks, rises, wrapLen;
  int          reads = 0;

  mior_link_if link ();
  mior_device mior_device_inst (.core_clk, .nrst, .link(link),
    .quadLaneEnable, .fourLaneCommandMode, .resetCmd, .setWrap,
    .wrapBits, .setReadParams, .dummySelIn, .memData, .memAddr,
    .memRead, .continuationActive);
  mior_host mior_host_inst (.core_clk, .nrst, .link(link), .reqValid,
    .reqCmd, .reqAddr, .reqCont, .reqDummy, .reqBytes, .reqSkipCmd,
    .reqQpi, .reqExit, .busy, .rdData, .rdValid);
  mior_link_monitor mior_link_monitor_inst (.core_clk, .nrst,
    .csN(link.csN), .sclk(link.sclk), .hostOut(link.hostOut),
    .hostOeN(link.hostOeN), .devOut(link.devOut), .devOeN(link.devOeN));

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  function automatic logic [7:0] fd(input logic [23:0] a);
    fd = a[7:0] ^ a[15:8] ^ 8'hA5;
  endfunction

  // Memory answers in the address cycle; device takes it one edge later
  assign memData = fd(memAddr);

  always @(posedge core_clk) begin
    if (memRead === 1'b1) reads <= reads + 1;
    sclkD <= link.sclk;
    if (!sclkD && link.sclk) rises <= rises + 1;
  end

  task check(input logic ok, input string msg);
    total_checks++;
    if (!ok) begin
      num_errors++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask

  task conclude;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task setw(input logic [2:0] b);
    setWrap <= 1'b1;
    wrapBits <= b;
    @(posedge core_clk);
    setWrap <= 1'b0;
    @(posedge core_clk);
    wrapOn = !b[0];
    wrapLen = 8 << b[2:1];
  endtask

  task params(input logic [1:0] s);
    setReadParams <= 1'b1;
    dummySelIn <= s;
    @(posedge core_clk);
    setReadParams <= 1'b0;
    @(posedge core_clk);
  endtask

  // One frame; expected bytes and link clock count from the rules
  task rd(input logic [7:0] cmd, input logic [23:0] a,
          input logic [7:0] m, input logic [5:0] dum, input int n,
          input logic skip, input logic ex, input logic bad);
    int got, r0, ln, clk, ad, t, rd0;
    logic wr;
    ln = (cmd == mior_pkg::CMD_DUAL_IO) ? 2 : 4;
    wr = wrapOn && ln == 4 && !fourLaneCommandMode;
    clk = (skip ? 0 : (fourLaneCommandMode ? 2 : 8)) + 32 / ln + dum;
    clk = ex ? 32 / ln : clk + n * 8 / ln;
    got = 0;
    t = 0;
    r0 = rises;
    rd0 = reads;
    reqValid <= 1'b1;
    reqCmd <= cmd;
    reqAddr <= a;
    reqCont <= m;
    reqDummy <= dum;
    reqBytes <= 8'(n);
    reqSkipCmd <= skip;
    reqQpi <= fourLaneCommandMode;
    reqExit <= ex;
    @(posedge core_clk);
    reqValid <= 1'b0;
    while ((t < 2 || busy !== 1'b0) && t < 6000) begin
      @(posedge core_clk);
      t++;
      if (rdValid === 1'b1) begin
        ad = int'(a) + got;
        if (wr) ad = (int'(a) & ~(wrapLen - 1)) | (ad & (wrapLen - 1));
        check(rdData === (bad ? 8'hFF : fd(24'(ad))), "read data");
        got++;
      end
    end
    check(t < 6000, "frame timeout");
    check(got == (ex ? 0 : n), "byte count");
    check(reads - rd0 == (bad ? 0 : ex ? int'(ln == 2) : n + 1),
          "memory fetches");
    check(rises - r0 == clk, "link clock count");
  endtask

  task t_quad;
    rd(mior_pkg::CMD_QUAD_IO, 24'h0001FE, 8'h00, 6'h04, 4, 0, 0, 1);
    quadLaneEnable <= 1'b1;
    @(posedge core_clk);
    rd(mior_pkg::CMD_QUAD_IO, 24'h0001FE, 8'h00, 6'h04, 4, 0, 0, 0);
    for (int k = 0; k < 4; k++) begin
      setw({2'(k), 1'b0});
      rd(mior_pkg::CMD_QUAD_IO, 24'(254 + (8 << k)), 8'h0F, 6'h04, 4,
         0, 0, 0);
    end
    rd(mior_pkg::CMD_QUAD_IO, 24'h000330, 8'h20, 6'h04, 2, 0, 0, 0);
    check(continuationActive === 1'b1, "quad continuation");
    rd(mior_pkg::CMD_QUAD_IO, 24'h000340, 8'h20, 6'h04, 2, 1, 0, 0);
    rd(mior_pkg::CMD_QUAD_IO, 24'h0, 8'h00, 6'h00, 1, 0, 1, 0);
    check(continuationActive === 1'b0, "quad exit");
    setw(3'h1);
  endtask

  task t_dual;
    rd(mior_pkg::CMD_DUAL_IO, 24'h012345, 8'h2F, 6'h00, 3, 0, 0, 0);
    check(continuationActive === 1'b1, "low nibble ignored");
    rd(mior_pkg::CMD_DUAL_IO, 24'h0123FF, 8'hA0, 6'h00, 2, 1, 0, 0);
    rd(mior_pkg::CMD_DUAL_IO, 24'h0, 8'h00, 6'h00, 1, 0, 1, 0);
    check(continuationActive === 1'b0, "dual exit");
    rd(mior_pkg::CMD_DUAL_IO, 24'h000800, 8'h00, 6'h00, 1, 0, 0, 0);
  endtask

  task t_word;
    setw(3'h0);
    rd(mior_pkg::CMD_WORD_IO, 24'h00040C, 8'h20, 6'h02, 6, 0, 0, 0);
    rd(mior_pkg::CMD_WORD_IO, 24'h000500, 8'h30, 6'h02, 2, 1, 0, 0);
    check(continuationActive === 1'b0, "code 11 ends skip");
    rd(mior_pkg::CMD_WORD_IO, 24'h000600, 8'h00, 6'h02, 1, 0, 0, 0);
  endtask

  // Wrap stays enabled here; four-lane mode must ignore it
  task t_qpi;
    fourLaneCommandMode <= 1'b1;
    @(posedge core_clk);
    rd(mior_pkg::CMD_QUAD_IO, 24'h0007FE, 8'h00, 6'h00, 3, 0, 0, 0);
    for (int k = 0; k < 4; k++) begin
      params(2'(k));
      rd(mior_pkg::CMD_QUAD_IO, 24'(2304 + k * 16), 8'h00, 6'(2 * k), 2,
         0, 0, 0);
    end
    rd(mior_pkg::CMD_QUAD_IO, 24'h000A00, 8'h20, 6'h06, 2, 0, 0, 0);
    check(continuationActive === 1'b1, "four-lane continuation");
    rd(mior_pkg::CMD_QUAD_IO, 24'h000A10, 8'h00, 6'h06, 2, 1, 0, 0);
    resetCmd <= 1'b1;
    @(posedge core_clk);
    resetCmd <= 1'b0;
    @(posedge core_clk);
    wrapOn = 1'b0;
    rd(mior_pkg::CMD_QUAD_IO, 24'h000B00, 8'h00, 6'h00, 2, 0, 0, 0);
  endtask

  initial begin
    {nrst, quadLaneEnable, fourLaneCommandMode, resetCmd} = 4'h0;
    {setWrap, setReadParams, reqValid, reqSkipCmd, reqQpi} = 5'h00;
    {reqExit, wrapOn, sclkD} = 3'h0;
    {wrapBits, dummySelIn, reqCmd, reqCont} = 21'h0;
    {reqBytes, reqAddr, reqDummy} = 38'h0;
    {num_errors, total_checks, rises, wrapLen} = {32'd0, 32'd0, 32'd0, 32'd8};
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    t_quad;
    t_dual;
    t_word;
    t_qpi;
    conclude;
  end

  // Whole run needs well under a quarter of this span
  initial begin
    #400000;
    num_errors++;
    conclude;
  end
endmodule
